// File: pdsb_pkg.sv
// Purpose: Shared constants for the detailed status bits block
// Assumes: 4B/5B code groups, serial management frames MSB first
// Notes:   Bit positions follow the 16-bit detailed status word
package pdsb_pkg;

	// ----------------------------------------
	// Register word layout
	// ----------------------------------------
	localparam logic [4:0] REG_ADDR      = 5'h11;
	localparam int         POS_SIG_LOST  = 10;
	localparam int         POS_EARLY_END = 5;
	localparam int         POS_AN_DONE   = 4;
	localparam int         POS_SIG_DET   = 3;
	localparam int         POS_JABBER    = 2;
	localparam int         POS_RFAULT    = 1;
	localparam int         POS_LINK      = 0;
	localparam int         EVT_BITS      = 6;
	localparam logic [4:0] UPPER_ZERO    = 5'h00;
	localparam logic [5:0] EVT_RESET     = 6'h00;

	// ----------------------------------------
	// Management frame
	// ----------------------------------------
	localparam logic [5:0] PRE_BITS  = 6'h20;
	localparam logic [1:0] OP_READ   = 2'h2;
	localparam logic [4:0] HDR_LAST  = 5'h0b;
	localparam logic [4:0] TA_LAST   = 5'h01;
	localparam logic [4:0] DATA_LAST = 5'h0f;

	// ----------------------------------------
	// Code groups
	// ----------------------------------------
	localparam logic [4:0] SYM_IDLE = 5'h1f;
	localparam logic [4:0] SYM_J    = 5'h18;
	localparam logic [4:0] SYM_K    = 5'h11;
	localparam logic [4:0] SYM_T    = 5'h0d;
	localparam logic [4:0] SYM_HALT = 5'h04;

	typedef enum logic [4:0] {
		MS_PRE   = 5'h01,
		MS_START = 5'h02,
		MS_HDR   = 5'h04,
		MS_TURN  = 5'h08,
		MS_DATA  = 5'h10
	} pdsb_mgmt_state_t;

	typedef enum logic [3:0] {
		RS_IDLE  = 4'h1,
		RS_GOTJ  = 4'h2,
		RS_PKT   = 4'h4,
		RS_WAIT  = 4'h8
	} pdsb_rx_state_t;

	// Code groups that carry no meaning at all in the 4B/5B set
	function automatic logic isInvalidCode(input logic [4:0] code);
		case (code)
			5'h00, 5'h01, 5'h02, 5'h03, 5'h05,
			5'h06, 5'h08, 5'h0c, 5'h10, 5'h19: isInvalidCode = 1'b1;
			default: isInvalidCode = 1'b0;
		endcase
	endfunction

endpackage

// File: pdsb_sym_if.sv
// Purpose: Carries code groups in and receive events out
// Assumes: One code group per clock when symValid is high
// Notes:   Event signals are one-cycle pulses
interface pdsb_sym_if;
	logic [4:0] sym;
	logic       symValid;
	logic       enable100;
	logic       evtFalseCarrier;
	logic       evtInvalid;
	logic       evtHalt;
	logic       evtEarlyEnd;
	logic       rxError;

	modport checker_side (
		input  sym, symValid, enable100,
		output evtFalseCarrier, evtInvalid, evtHalt, evtEarlyEnd, rxError
	);
	modport owner_side (
		output sym, symValid, enable100,
		input  evtFalseCarrier, evtInvalid, evtHalt, evtEarlyEnd, rxError
	);
endinterface

// File: pdsb_sym_check.sv
// Purpose: Watches received code groups for error conditions
// Assumes: Code groups already aligned and descrambled
// Notes:   Silent outside 100 Mb/s mode
module pdsb_sym_check (
	// Clock and reset
	input wire logic            clk,
	input wire logic            reset,
	// Symbol stream and events
	pdsb_sym_if.checker_side    sif
);
	typedef struct packed {
		pdsb_pkg::pdsb_rx_state_t st;
		logic                     prevIdle;
		logic                     falseCarrier;
		logic                     invalid;
		logic                     halt;
		logic                     earlyEnd;
		logic                     rxError;
	} pdsb_chk_s_t;

	pdsb_chk_s_t s_r;
	pdsb_chk_s_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.falseCarrier = 1'b0;
		s_nxt.invalid = 1'b0;
		s_nxt.halt = 1'b0;
		s_nxt.earlyEnd = 1'b0;
		s_nxt.rxError = 1'b0;
		if (!sif.enable100) begin
			// Event meaning is undefined at 10 Mb/s, so stay quiet
			s_nxt.st = pdsb_pkg::RS_IDLE;
			s_nxt.prevIdle = 1'b0;
		end else if (sif.symValid) begin
			case (s_r.st)
				pdsb_pkg::RS_IDLE: begin
					if (sif.sym == pdsb_pkg::SYM_J) begin
						s_nxt.st = pdsb_pkg::RS_GOTJ;
					end else if (sif.sym != pdsb_pkg::SYM_IDLE) begin
						s_nxt.falseCarrier = 1'b1;
						s_nxt.st = pdsb_pkg::RS_WAIT;
					end
				end
				pdsb_pkg::RS_GOTJ: begin
					if (sif.sym == pdsb_pkg::SYM_K) begin
						s_nxt.st = pdsb_pkg::RS_PKT;
						s_nxt.prevIdle = 1'b0;
					end else begin
						s_nxt.falseCarrier = 1'b1;
						s_nxt.st = pdsb_pkg::RS_WAIT;
					end
				end
				pdsb_pkg::RS_PKT: begin
					s_nxt.prevIdle = (sif.sym == pdsb_pkg::SYM_IDLE);
					if (sif.sym == pdsb_pkg::SYM_T) begin
						s_nxt.st = pdsb_pkg::RS_WAIT;
					end else if (sif.sym == pdsb_pkg::SYM_HALT) begin
						s_nxt.halt = 1'b1;
						s_nxt.rxError = 1'b1;
					end else if (pdsb_pkg::isInvalidCode(sif.sym)) begin
						s_nxt.invalid = 1'b1;
						s_nxt.rxError = 1'b1;
					end else if (sif.sym == pdsb_pkg::SYM_IDLE && s_r.prevIdle) begin
						s_nxt.earlyEnd = 1'b1;
						s_nxt.rxError = 1'b1;
						s_nxt.st = pdsb_pkg::RS_IDLE;
					end
				end
				pdsb_pkg::RS_WAIT: begin
					if (sif.sym == pdsb_pkg::SYM_IDLE) begin
						s_nxt.st = pdsb_pkg::RS_IDLE;
					end
				end
				default: s_nxt.st = pdsb_pkg::RS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_r <= '{st: pdsb_pkg::RS_IDLE, default: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sif.evtFalseCarrier = s_r.falseCarrier;
	assign sif.evtInvalid      = s_r.invalid;
	assign sif.evtHalt         = s_r.halt;
	assign sif.evtEarlyEnd     = s_r.earlyEnd;
	assign sif.rxError         = s_r.rxError;
endmodule

// File: pdsb_latch_bank.sv
// Purpose: Latching-high event bits
// Assumes: clr is a one-cycle pulse per bit
// Notes:   A set in the clearing cycle wins
module pdsb_latch_bank (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          reset,
	// Events and clears
	input  wire logic [pdsb_pkg::EVT_BITS-1:0] set,
	input  wire logic [pdsb_pkg::EVT_BITS-1:0] clr,
	// Latched bits
	output logic      [pdsb_pkg::EVT_BITS-1:0] bits
);
	typedef struct packed {
		logic [pdsb_pkg::EVT_BITS-1:0] bits;
	} pdsb_latch_s_t;

	pdsb_latch_s_t s_r;
	pdsb_latch_s_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		for (int i = 0; i < pdsb_pkg::EVT_BITS; i++) begin
			s_nxt.bits[i] = set[i] | (s_r.bits[i] & ~clr[i]);
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_r <= '{bits: pdsb_pkg::EVT_RESET};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign bits = s_r.bits;
endmodule

// File: pdsb_status_top.sv
// Purpose: Detailed status bits 10..0 behind the management port
// Assumes: mdc and mdioIn synchronous to clk, clk much faster than mdc
// Notes:   Only reads of the quick poll status word answer; 15..11 read 0
module pdsb_status_top (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// Management port
	input  wire logic       mdc,
	input  wire logic       mdioIn,
	output logic            mdioOut,
	output logic            mdioOe,
	input  wire logic [4:0] phyAddr,
	// Mode and receive path status
	input  wire logic       speed100,
	input  wire logic       signalDetect100,
	input  wire logic       pllLockFail,
	input  wire logic [4:0] rxSym,
	input  wire logic       rxSymValid,
	// Negotiation and basic status mirrors
	input  wire logic       autoNegEnable,
	input  wire logic       autoNegComplete,
	input  wire logic       jabberDetect,
	input  wire logic       remoteFault,
	input  wire logic       linkStatus,
	// Toward the MAC
	output logic            rxError,
	output logic [15:0]     statusWord
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		pdsb_pkg::pdsb_mgmt_state_t st;
		logic                       mdcPrev;
		logic [5:0]                 preCnt;
		logic [4:0]                 bitCnt;
		logic [11:0]                hdr;
		logic                       reading;
		logic [15:0]                shift;
		logic [5:0]                 snap;
		logic [5:0]                 clr;
		logic                       mdioOut;
		logic                       mdioOe;
		logic [15:0]                word;
	} pdsb_top_s_t;

	pdsb_top_s_t s_r;
	pdsb_top_s_t s_nxt;

	logic [pdsb_pkg::EVT_BITS-1:0] evtSet;
	logic [pdsb_pkg::EVT_BITS-1:0] evtBits;
	logic [15:0]                   liveWord;
	logic                          mdcRise;
	logic                          hdrMatch;
	logic [11:0]                   hdrFull;

	pdsb_sym_if sif ();

	assign sif.sym       = rxSym;
	assign sif.symValid  = rxSymValid;
	assign sif.enable100 = speed100;

	// ----------------------------------------
	// Receive checks and latched bits
	// ----------------------------------------
	pdsb_sym_check i_pdsb_sym_check (
		.clk   (clk),
		.reset (reset),
		.sif   (sif)
	);

	always_comb begin
		evtSet = pdsb_pkg::EVT_RESET;
		if (speed100) begin
			evtSet[5] = ~signalDetect100;
			evtSet[4] = pllLockFail;
		end
		evtSet[3] = sif.evtFalseCarrier;
		evtSet[2] = sif.evtInvalid;
		evtSet[1] = sif.evtHalt;
		evtSet[0] = sif.evtEarlyEnd;
	end

	pdsb_latch_bank i_pdsb_latch_bank (
		.clk   (clk),
		.reset (reset),
		.set   (evtSet),
		.clr   (s_r.clr),
		.bits  (evtBits)
	);

	// ----------------------------------------
	// Live register image
	// ----------------------------------------
	always_comb begin
		liveWord = 16'h0000;
		liveWord[15:11] = pdsb_pkg::UPPER_ZERO;
		liveWord[pdsb_pkg::POS_SIG_LOST:pdsb_pkg::POS_EARLY_END] = evtBits;
		// Complete is only trusted while negotiation is enabled
		liveWord[pdsb_pkg::POS_AN_DONE] = autoNegEnable & autoNegComplete;
		liveWord[pdsb_pkg::POS_SIG_DET] = speed100 & signalDetect100;
		liveWord[pdsb_pkg::POS_JABBER] = jabberDetect;
		liveWord[pdsb_pkg::POS_RFAULT] = remoteFault;
		liveWord[pdsb_pkg::POS_LINK] = linkStatus;
	end

	// ----------------------------------------
	// Management frame engine
	// ----------------------------------------
	assign mdcRise  = mdc & ~s_r.mdcPrev;
	assign hdrFull  = {s_r.hdr[10:0], mdioIn};
	assign hdrMatch = (hdrFull[11:10] == pdsb_pkg::OP_READ) &&
		(hdrFull[9:5] == phyAddr) && (hdrFull[4:0] == pdsb_pkg::REG_ADDR);

	always_comb begin
		s_nxt = s_r;
		s_nxt.mdcPrev = mdc;
		s_nxt.clr = pdsb_pkg::EVT_RESET;
		s_nxt.word = liveWord;
		if (mdcRise) begin
			case (s_r.st)
				pdsb_pkg::MS_PRE: begin
					if (mdioIn) begin
						if (s_r.preCnt != pdsb_pkg::PRE_BITS) begin
							s_nxt.preCnt = s_r.preCnt + 6'h01;
						end
					end else if (s_r.preCnt == pdsb_pkg::PRE_BITS) begin
						s_nxt.st = pdsb_pkg::MS_START;
					end else begin
						s_nxt.preCnt = 6'h00;
					end
				end
				pdsb_pkg::MS_START: begin
					s_nxt.preCnt = 6'h00;
					s_nxt.bitCnt = 5'h00;
					s_nxt.st = mdioIn ? pdsb_pkg::MS_HDR : pdsb_pkg::MS_PRE;
				end
				pdsb_pkg::MS_HDR: begin
					s_nxt.hdr = hdrFull;
					s_nxt.bitCnt = s_r.bitCnt + 5'h01;
					if (s_r.bitCnt == pdsb_pkg::HDR_LAST) begin
						s_nxt.st = pdsb_pkg::MS_TURN;
						s_nxt.bitCnt = 5'h00;
						s_nxt.reading = hdrMatch;
						// Snapshot now so the answer shows current values
						s_nxt.shift = liveWord;
						s_nxt.snap = evtBits;
					end
				end
				pdsb_pkg::MS_TURN: begin
					s_nxt.bitCnt = s_r.bitCnt + 5'h01;
					if (s_r.bitCnt == pdsb_pkg::TA_LAST) begin
						s_nxt.st = pdsb_pkg::MS_DATA;
						s_nxt.bitCnt = 5'h00;
						s_nxt.mdioOut = s_r.shift[15];
						s_nxt.shift = {s_r.shift[14:0], 1'b0};
					end else begin
						// Second turnaround bit is a driven zero
						s_nxt.mdioOe = s_r.reading;
						s_nxt.mdioOut = 1'b0;
					end
				end
				pdsb_pkg::MS_DATA: begin
					s_nxt.bitCnt = s_r.bitCnt + 5'h01;
					s_nxt.mdioOut = s_r.shift[15];
					s_nxt.shift = {s_r.shift[14:0], 1'b0};
					if (s_r.bitCnt == pdsb_pkg::DATA_LAST) begin
						s_nxt.st = pdsb_pkg::MS_PRE;
						s_nxt.mdioOe = 1'b0;
						s_nxt.mdioOut = 1'b0;
						s_nxt.bitCnt = 5'h00;
						// Only bits seen as one are cleared; newer sets win
						if (s_r.reading) begin
							s_nxt.clr = s_r.snap;
						end
						s_nxt.reading = 1'b0;
					end
				end
				default: begin
					s_nxt.st = pdsb_pkg::MS_PRE;
					s_nxt.mdioOe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_r <= '{st: pdsb_pkg::MS_PRE, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign mdioOut    = s_r.mdioOut;
	assign mdioOe     = s_r.mdioOe;
	assign rxError    = sif.rxError;
	assign statusWord = s_r.word;
endmodule

// File: pdsb_status_checker.sv
// Purpose: Port-level assertions for the detailed status bits
// Assumes: statusWord is the live image one clock late
// Notes:   Sees only ports of pdsb_status_top
module pdsb_status_checker (
	// Clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// Management port
	input wire logic        mdioOe,
	// Status inputs
	input wire logic        speed100,
	input wire logic        signalDetect100,
	input wire logic        pllLockFail,
	input wire logic        autoNegEnable,
	input wire logic        autoNegComplete,
	input wire logic        jabberDetect,
	input wire logic        remoteFault,
	input wire logic        linkStatus,
	// Outputs watched
	input wire logic        rxError,
	input wire logic [15:0] statusWord
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// ----------------------------------------
	// Live bits
	// ----------------------------------------
	a_basic_mirror: assert property (
		!$past(reset) |-> statusWord[2:0] ==
			$past({jabberDetect, remoteFault, linkStatus}))
		else $error("mirror bits differ");
	a_neg_done: assert property (
		!$past(reset) |->
			statusWord[4] == $past(autoNegEnable & autoNegComplete))
		else $error("negotiation bit wrong");
	a_sig_detect: assert property (
		!$past(reset) |-> statusWord[3] == $past(speed100 & signalDetect100))
		else $error("signal detect bit wrong");

	// ----------------------------------------
	// Latched bits
	// ----------------------------------------
	a_loss_sets: assert property (
		speed100 && !signalDetect100 |-> ##2 statusWord[10])
		else $error("signal loss not latched");
	a_lock_sets: assert property (
		speed100 && pllLockFail |-> ##2 statusWord[9])
		else $error("lock failure not latched");
	a_err_latch: assert property (
		rxError |-> ##[1:3] (|statusWord[7:5]))
		else $error("receive error without latched bit");
	a_quiet_slow: assert property (
		!speed100 [*3] |-> !rxError)
		else $error("receive error at low speed");
	// Clears only shortly after a read frame releases the line
	a_clear_after: assert property (
		|($past(statusWord[10:5]) & ~statusWord[10:5]) |->
			$past(mdioOe, 2) || $past(mdioOe, 3) || $past(mdioOe, 4))
		else $error("latched bit cleared without read");

	c_err: cover property (rxError);
	c_read: cover property ($rose(mdioOe));
	c_clear: cover property ($fell(statusWord[10]));
endmodule

// File: pdsb_sta_model.sv
// Purpose: Station management entity issuing read frames
// Assumes: Four clocks per mdc period, two high and two low
// Notes:   Released line reads the pull-up level
module pdsb_sta_model (
	// Clock
	input wire logic clk,
	// Management line
	input wire logic mdioLine,
	output logic     mdc,
	output logic     staOut,
	output logic     staOe
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		mdc = 1'b0;
		staOut = 1'b1;
		staOe = 1'b0;
	end

	// Data sampled just before each rise, while the bit still stands
	// A write opcode still leaves the line released, so data reads as ones
	task automatic rd(input logic [1:0] op, input logic [4:0] pa,
			input logic [4:0] ra, output logic [15:0] d);
		logic [13:0] hdr;
		hdr = {2'b01, op, pa, ra};
		d = 16'h0000;
		for (int i = 1; i <= 64; i++) begin
			@(posedge clk);
			mdc <= 1'b0;
			staOe <= (i <= 46);
			staOut <= (i <= 32 || i > 46) ? 1'b1 : hdr[46 - i];
			@(posedge clk);
			if (i >= 49)
				d = {d[14:0], mdioLine};
			@(posedge clk);
			mdc <= 1'b1;
			@(posedge clk);
		end
		@(posedge clk);
		mdc <= 1'b0;
	endtask
endmodule

// File: pdsb_status_top_test.sv
// Purpose: Self-checking bench for the detailed status bits
// Assumes: Line pulled up when nobody drives it
// Notes:   Reads go through the management model
module pdsb_status_top_test;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [4:0] SD = 5'h1e;
	localparam logic [4:0] SJ = pdsb_pkg::SYM_J;
	localparam logic [4:0] SK = pdsb_pkg::SYM_K;
	localparam logic [4:0] ST = pdsb_pkg::SYM_T;
	localparam logic [4:0] SI = pdsb_pkg::SYM_IDLE;

	logic        clk, reset, mdc, mdioLine, mdioOut, mdioOe, staOut, staOe;
	logic        speed100, signalDetect100, pllLockFail, rxSymValid;
	logic        autoNegEnable, autoNegComplete, jabberDetect;
	logic        remoteFault, linkStatus, rxError;
	logic [4:0]  rxSym, phyAddr;
	logic [15:0] statusWord, got, base;
	logic [39:0] seqV [5];
	int          seqN [5] = '{1, 2, 5, 5, 5};
	int          seqBit [5] = '{8, 8, 7, 6, 5};
	int          seqErr [5] = '{0, 0, 1, 1, 1};
	int          badCount, comparisons, errPulses;

	assign mdioLine = mdioOe ? mdioOut : (staOe ? staOut : 1'b1);
	always #25 clk = ~clk;
	always @(posedge clk) if (rxError === 1'b1) errPulses++;

	pdsb_status_top i_pdsb_status_top (
		.clk(clk), .reset(reset), .mdc(mdc), .mdioIn(mdioLine),
		.mdioOut(mdioOut), .mdioOe(mdioOe), .phyAddr(phyAddr),
		.speed100(speed100), .signalDetect100(signalDetect100),
		.pllLockFail(pllLockFail), .rxSym(rxSym), .rxSymValid(rxSymValid),
		.autoNegEnable(autoNegEnable), .autoNegComplete(autoNegComplete),
		.jabberDetect(jabberDetect), .remoteFault(remoteFault),
		.linkStatus(linkStatus), .rxError(rxError), .statusWord(statusWord)
	);
	pdsb_sta_model i_pdsb_sta_model (
		.clk(clk), .mdioLine(mdioLine), .mdc(mdc), .staOut(staOut),
		.staOe(staOe)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			badCount++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrapUp;
		$display("comparisons %0d mismatches %0d", comparisons, badCount);
		if (badCount == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic readReg(input logic [15:0] exp);
		i_pdsb_sta_model.rd(pdsb_pkg::OP_READ, phyAddr,
			pdsb_pkg::REG_ADDR, got);
		tick(4);
		check(got, exp);
	endtask

	// Idles follow so the receive checker is back in its hunt
	task automatic syms(input logic [39:0] v, input int n);
		errPulses = 0;
		for (int k = 0; k < n; k++) begin
			@(posedge clk);
			rxSym <= v[39 - 5 * k -: 5];
			rxSymValid <= 1'b1;
		end
		@(posedge clk);
		rxSym <= SI;
		tick(3);
		rxSymValid <= 1'b0;
		tick(4);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		reset = 1'b1;
		phyAddr = 5'h05;
		{speed100, signalDetect100, pllLockFail} = 3'b110;
		rxSym = SI;
		rxSymValid = 1'b0;
		{autoNegEnable, autoNegComplete} = 2'b11;
		{jabberDetect, remoteFault, linkStatus} = 3'b001;
		badCount = 0;
		comparisons = 0;
		seqV[0] = {SD, 35'h0};
		seqV[1] = {SJ, SD, 30'h0};
		seqV[2] = {SJ, SK, SD, 5'h00, ST, 15'h0};
		seqV[3] = {SJ, SK, SD, pdsb_pkg::SYM_HALT, ST, 15'h0};
		seqV[4] = {SJ, SK, SD, SI, SI, 15'h0};
		tick(8);
		reset <= 1'b0;
		tick(3);
		readReg(16'h0019);
		$display("test reset done");
		for (int i = 0; i < 32; i++) begin
			{autoNegEnable, autoNegComplete, jabberDetect, remoteFault,
				linkStatus} <= i[4:0];
			tick(3);
			check(statusWord, {11'h0, i[4] & i[3], 1'b1, i[2:0]});
		end
		base = 16'h001f;
		$display("test live bits done");
		signalDetect100 <= 1'b0;
		pllLockFail <= 1'b1;
		tick(3);
		check(statusWord, base & 16'hfff7 | 16'h0600);
		signalDetect100 <= 1'b1;
		pllLockFail <= 1'b0;
		tick(3);
		check(statusWord, base | 16'h0600);
		readReg(base | 16'h0600);
		check(statusWord, base);
		pllLockFail <= 1'b1;
		readReg(base | 16'h0200);
		readReg(base | 16'h0200);
		pllLockFail <= 1'b0;
		readReg(base | 16'h0200);
		readReg(base);
		$display("test latch and clear done");
		i_pdsb_sta_model.rd(pdsb_pkg::OP_READ, phyAddr ^ 5'h01,
			pdsb_pkg::REG_ADDR, got);
		check(got, 16'hffff);
		i_pdsb_sta_model.rd(pdsb_pkg::OP_READ, phyAddr, 5'h12, got);
		check(got, 16'hffff);
		// Write opcode to a read-only word: never driven
		i_pdsb_sta_model.rd(2'h1, phyAddr, pdsb_pkg::REG_ADDR, got);
		check(got, 16'hffff);
		readReg(base);
		$display("test refused frames done");
		for (int k = 0; k < 5; k++) begin
			syms(seqV[k], seqN[k]);
			check(16'(errPulses), 16'(seqErr[k]));
			readReg(base | (16'h0001 << seqBit[k]));
		end
		$display("test code groups done");
		speed100 <= 1'b0;
		syms(seqV[2], seqN[2]);
		check(16'(errPulses), 16'h0000);
		readReg(base & 16'hfff7);
		speed100 <= 1'b1;
		pllLockFail <= 1'b1;
		tick(3);
		pllLockFail <= 1'b0;
		reset <= 1'b1;
		tick(2);
		reset <= 1'b0;
		tick(3);
		check(statusWord, base);
		$display("test second reset done");
		wrapUp();
	end

	initial begin
		repeat (100000) @(posedge clk);
		badCount++;
		wrapUp();
	end
endmodule

bind pdsb_status_top pdsb_status_checker i_pdsb_status_checker (
	.clk(clk), .reset(reset), .mdioOe(mdioOe), .speed100(speed100),
	.signalDetect100(signalDetect100), .pllLockFail(pllLockFail),
	.autoNegEnable(autoNegEnable), .autoNegComplete(autoNegComplete),
	.jabberDetect(jabberDetect), .remoteFault(remoteFault),
	.linkStatus(linkStatus), .rxError(rxError), .statusWord(statusWord)
);
